// ### verilog/panel_pin_map.svh
// Constants for the panel pin mapper: bus offsets, field positions, reset values.
// Assumes inclusion by bare name from the package and the design files.
`ifndef PANEL_PIN_MAP_MAP_SVH
`define PANEL_PIN_MAP_MAP_SVH

// -----------------------------------------------------------------------------
// Register offsets (byte addresses).
// -----------------------------------------------------------------------------
`define PPM_OFS_CTRL    12'h000
`define PPM_OFS_STATUS  12'h004
`define PPM_OFS_SIDEBND 12'h008

// -----------------------------------------------------------------------------
// Control register fields and reset value.
// -----------------------------------------------------------------------------
`define PPM_CTRL_MODE_LSB  0
`define PPM_CTRL_MODE_MSB  3
`define PPM_CTRL_SWAP_BIT  4
`define PPM_CTRL_THIN_BIT  5
`define PPM_CTRL_EXTCK_BIT 6
`define PPM_CTRL_RESET     32'h0000_0000

// -----------------------------------------------------------------------------
// Panel data field positions.
// -----------------------------------------------------------------------------
`define PPM_DATA_W      18
`define PPM_LOWER_LSB   8
`define PPM_INTENS_BIT  0
`define PPM_PS_BIT      6
`define PPM_REV_BIT     12
`define PPM_GREEN5_BIT  13

`endif

// ### verilog/panel_pin_pkg.sv
// Types shared by the panel pin mapper, the panel model and the bench.
// Assumes the constants header sits in the include path.
package panel_pin_pkg;
  `include "panel_pin_map.svh"

  // Panel types, one-hot.
  typedef enum logic [7:0] {
    MODE_MONO4_SINGLE = 8'h01,
    MODE_MONO4_DUAL   = 8'h02,
    MODE_MONO8_SINGLE = 8'h04,
    MODE_MONO8_DUAL   = 8'h08,
    MODE_COLOUR_SGL   = 8'h10,
    MODE_COLOUR_DUAL  = 8'h20,
    MODE_TFT_555I     = 8'h40,
    MODE_TFT_565      = 8'h80
  } panel_mode_e;

  // One pixel word with its timing, as the pipeline hands it over.
  typedef struct packed {
    logic [7:0] upper;     // Upper-panel STN bits.
    logic [7:0] lower;     // Lower-panel STN bits.
    logic [4:0] red;
    logic [5:0] green;
    logic [4:0] blue;
    logic       intensity;
    logic       frame;
    logic       line;
    logic       enable;
  } pixel_word_s;

  // Panel-facing pins.
  typedef struct packed {
    logic [`PPM_DATA_W-1:0] data;
    logic                   frame;
    logic                   line;
    logic                   enab;
    logic                   supply;
  } panel_pins_s;
endpackage

// ### verilog/pixel_fifo.sv
// Synchronous FIFO for pixel words in front of the panel pin mapper.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/100ps
`default_nettype none

module pixel_fifo #(
  parameter int WIDTH = 42,
  parameter int DEPTH = 16
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("pixel_fifo depth must be a power of two");
  end

  // Storage is a plain array; pointers carry one extra wrap bit.
  logic [WIDTH-1:0] mem [DEPTH];

  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } fifo_state_s;

  fifo_state_s st_r, st_nxt;
  logic        push, pop;

  assign in_ready  = (st_r.wp ^ st_r.rp) != {1'b1, {AW{1'b0}}};
  assign out_valid = st_r.wp != st_r.rp;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[st_r.rp[AW-1:0]];

  // Pointer advance.
  always_comb begin
    st_nxt = st_r;
    if (push) st_nxt.wp = st_r.wp + 1'b1;
    if (pop)  st_nxt.rp = st_r.rp + 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // The array holds no reset; only the pointers decide what is valid.
  always_ff @(posedge hclk) begin
    if (push) mem[st_r.wp[AW-1:0]] <= in_data;
  end
endmodule

`default_nettype wire

// ### verilog/lcd_panel_pin_mapper.sv
// Output stage of the colour LCD controller: maps pixel words and timing onto the panel pins.
// Assumes an AHB-Lite master for control, the pixel pipeline on hclk, and an external pixel clock
// that is only sampled (through two flops) to pace the panel data clock.
`timescale 1ns/100ps
`default_nettype none
`include "panel_pin_map.svh"

module lcd_panel_pin_mapper
  import panel_pin_pkg::*;
#(
  parameter int FIFO_DEPTH = 16,
  parameter int CLK_DIV    = 2
) (
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   hsel,
  input  wire logic [11:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic                        hresp,
  output logic      [31:0]            hrdata,
  input  wire logic                   pix_valid,
  output logic                        pix_ready,
  input  wire pixel_word_s            pix_word,
  input  wire logic                   external_pixel_clock_in,
  output logic      [`PPM_DATA_W-1:0] panel_data_out,
  output logic                        frame_pulse_out,
  output logic                        line_pulse_out,
  output logic                        panel_data_enable,
  output logic                        panel_supply_enable,
  output logic                        panel_pixel_clock
);
  localparam int WW = $bits(pixel_word_s);
  localparam int CW = $clog2(CLK_DIV + 1);

  initial begin
    if (CLK_DIV < 2) $error("CLK_DIV must be at least 2");
    if (FIFO_DEPTH < 2) $error("FIFO_DEPTH must be at least 2");
  end

  // ---------------------------------------------------------------------------
  // State of the whole block apart from the pixel FIFO.
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic        ap_valid;      // A write address phase awaits its data.
    logic [11:0] ap_addr;
    logic [31:0] rdata;
    logic [3:0]  mode_sel;      // Index of the panel type.
    logic        swap;          // Colour order swap.
    logic        thin;          // Thin-panel TFT mode.
    logic        ext_clk;       // Pace the panel clock from the external input.
    logic        supply_on;     // Digital supply enable level.
    logic        power_save;    // Thin-mode power save level.
    logic        reverse;       // Thin-mode reverse level.
    logic        gate_clk;      // Thin-mode gate driver clock level.
    logic [1:0]  ext_sync;      // Two-flop synchroniser for the external clock.
    logic        ext_prev;
    logic [CW-1:0] div_cnt;
    logic        pclk;
    logic [15:0] words_out;     // Count of pixel words put on the pins.
    panel_pins_s pins;
  } mapper_state_s;

  mapper_state_s st_r, st_nxt;

  // ---------------------------------------------------------------------------
  // Pixel FIFO in front of the mapper.
  // ---------------------------------------------------------------------------
  logic        fifo_valid;
  logic        fifo_pop;
  logic [WW-1:0] fifo_data;
  pixel_word_s word;

  pixel_fifo #(
    .WIDTH (WW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .in_valid  (pix_valid),
    .in_ready  (pix_ready),
    .in_data   (pix_word),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  assign word = pixel_word_s'(fifo_data);

  // ---------------------------------------------------------------------------
  // Helpers for the bus and the clock edge.
  // ---------------------------------------------------------------------------
  logic        bus_req;
  logic        pclk_rise;
  panel_mode_e mode;
  logic [`PPM_DATA_W-1:0] data_map;
  logic [4:0]  lo_col, hi_col;

  assign bus_req   = hsel && hready && htrans[1];
  assign mode      = panel_mode_e'(8'h01 << st_r.mode_sel[2:0]);
  // A rising panel clock edge is the only moment that any pin changes.
  assign pclk_rise = st_r.ext_clk ? (st_r.ext_sync[1] && !st_r.ext_prev)
                                  : (st_r.div_cnt == CW'(CLK_DIV - 1) && !st_r.pclk);
  assign fifo_pop  = pclk_rise && fifo_valid;
  assign lo_col    = st_r.swap ? word.blue : word.red;
  assign hi_col    = st_r.swap ? word.red : word.blue;

  // ---------------------------------------------------------------------------
  // Data pin mapping per panel type; every bit not set below stays low.
  // ---------------------------------------------------------------------------
  always_comb begin
    data_map = '0;
    case (mode)
      MODE_MONO4_SINGLE: data_map[3:0] = word.upper[3:0];
      MODE_MONO4_DUAL: begin
        data_map[3:0]   = word.upper[3:0];
        data_map[11:8]  = word.lower[3:0];
      end
      MODE_MONO8_SINGLE, MODE_COLOUR_SGL: data_map[7:0] = word.upper;
      MODE_MONO8_DUAL, MODE_COLOUR_DUAL: begin
        data_map[7:0]   = word.upper;
        data_map[15:8]  = word.lower;
      end
      MODE_TFT_555I: begin
        data_map[5:1]   = lo_col;
        data_map[11:7]  = word.green[4:0];
        data_map[17:13] = hi_col;
        data_map[`PPM_INTENS_BIT] = word.intensity;
      end
      MODE_TFT_565: begin
        data_map[5:1]   = lo_col;
        data_map[11:7]  = word.green[4:0];
        data_map[`PPM_GREEN5_BIT] = word.green[5];
        data_map[17:14] = hi_col[3:0];
        data_map[0]     = hi_col[4];
      end
      default: data_map = '0;
    endcase
    // Thin-panel extras take the two unused TFT positions.
    if (st_r.thin) begin
      data_map[`PPM_PS_BIT]  = st_r.power_save;
      data_map[`PPM_REV_BIT] = st_r.reverse;
    end
  end

  // ---------------------------------------------------------------------------
  // Next state: bus slave, clock pacing and pin update.
  // ---------------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // The first sync flop feeds only the second.
    st_nxt.ext_sync = {st_r.ext_sync[0], external_pixel_clock_in};
    st_nxt.ext_prev = st_r.ext_sync[1];

    // Internal divider runs always so the switch between sources is glitch-free in effect.
    if (st_r.div_cnt == CW'(CLK_DIV - 1)) begin
      st_nxt.div_cnt = '0;
      st_nxt.pclk    = !st_r.pclk;
    end else begin
      st_nxt.div_cnt = st_r.div_cnt + 1'b1;
    end

    // In external mode the panel clock is the synchronised input itself, so the divider cannot glitch it.
    if (st_r.ext_clk) st_nxt.pclk = st_r.ext_sync[1];

    // Register write data phase.
    st_nxt.ap_valid = 1'b0;
    if (st_r.ap_valid) begin
      case (st_r.ap_addr)
        `PPM_OFS_CTRL: begin
          st_nxt.mode_sel  = hwdata[`PPM_CTRL_MODE_MSB:`PPM_CTRL_MODE_LSB];
          st_nxt.swap      = hwdata[`PPM_CTRL_SWAP_BIT];
          st_nxt.thin      = hwdata[`PPM_CTRL_THIN_BIT];
          st_nxt.ext_clk   = hwdata[`PPM_CTRL_EXTCK_BIT];
        end
        `PPM_OFS_SIDEBND: begin
          st_nxt.supply_on  = hwdata[0];
          st_nxt.power_save = hwdata[1];
          st_nxt.reverse    = hwdata[2];
          st_nxt.gate_clk   = hwdata[3];
        end
        default: st_nxt.ap_valid = 1'b0;
      endcase
    end

    // Address phase: capture writes, prepare read data for the data phase.
    if (bus_req) begin
      st_nxt.ap_valid = hwrite;
      st_nxt.ap_addr  = {haddr[11:2], 2'b00};
      case ({haddr[11:2], 2'b00})
        `PPM_OFS_CTRL:    st_nxt.rdata = {25'h0, st_r.ext_clk, st_r.thin, st_r.swap, st_r.mode_sel};
        `PPM_OFS_STATUS:  st_nxt.rdata = {st_r.words_out, 14'h0, pix_ready, fifo_valid};
        `PPM_OFS_SIDEBND: st_nxt.rdata = {28'h0, st_r.gate_clk, st_r.reverse, st_r.power_save,
                                          st_r.supply_on};
        default:          st_nxt.rdata = 32'h0;
      endcase
    end

    // All pins move together on the panel clock rising edge.
    if (pclk_rise) begin
      if (fifo_valid) begin
        st_nxt.pins.data  = data_map;
        st_nxt.pins.frame = word.frame;
        st_nxt.pins.line  = word.line;
        st_nxt.pins.enab  = word.enable;
        st_nxt.words_out  = st_r.words_out + 1'b1;
      end else begin
        st_nxt.pins.data  = st_r.thin ? data_map & ((18'h1 << `PPM_PS_BIT) | (18'h1 << `PPM_REV_BIT))
                                      : '0;
        st_nxt.pins.enab  = 1'b0;
      end
      st_nxt.pins.supply = st_r.thin ? st_r.gate_clk : st_r.supply_on;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs: all from flops except hreadyout and hresp, which are tied to constants, and pix_ready, decoded from the FIFO pointers.
  // ---------------------------------------------------------------------------
  assign hreadyout           = 1'b1;
  assign hresp               = 1'b0;
  assign hrdata              = st_r.rdata;
  assign panel_data_out      = st_r.pins.data;
  assign frame_pulse_out     = st_r.pins.frame;
  assign line_pulse_out      = st_r.pins.line;
  assign panel_data_enable   = st_r.pins.enab;
  assign panel_supply_enable = st_r.pins.supply;
  assign panel_pixel_clock   = st_r.pclk;

  // ---------------------------------------------------------------------------
  // Checks.
  // ---------------------------------------------------------------------------
  property p_mono4_map;
    @(posedge hclk) disable iff (!hresetn)
      (pclk_rise && fifo_valid && mode == MODE_MONO4_SINGLE) |=> panel_data_out == {14'h0, $past(word.upper[3:0])};
  endproperty
  a_mono4_map: assert property (p_mono4_map) else $error("mono 4-bit map wrong");

  property p_dual4_lower;
    @(posedge hclk) disable iff (!hresetn)
      (pclk_rise && fifo_valid && mode == MODE_MONO4_DUAL) |=> panel_data_out[11:8] == $past(word.lower[3:0]);
  endproperty
  a_dual4_lower: assert property (p_dual4_lower) else $error("dual 4-bit lower map wrong");

  property p_dual8_map;
    @(posedge hclk) disable iff (!hresetn)
      (pclk_rise && fifo_valid && mode == MODE_COLOUR_DUAL && !st_r.thin)
        |=> panel_data_out == {2'b00, $past(word.lower), $past(word.upper)};
  endproperty
  a_dual8_map: assert property (p_dual8_map) else $error("dual 8-bit map wrong");

  property p_tft_red;
    @(posedge hclk) disable iff (!hresetn)
      (pclk_rise && fifo_valid && mode == MODE_TFT_565 && !st_r.swap)
        |=> panel_data_out[5:1] == $past(word.red) && panel_data_out[0] == $past(word.blue[4]);
  endproperty
  a_tft_red: assert property (p_tft_red) else $error("5:6:5 red or blue4 map wrong");

  property p_intensity;
    @(posedge hclk) disable iff (!hresetn)
      (pclk_rise && fifo_valid && mode == MODE_TFT_555I) |=> panel_data_out[0] == $past(word.intensity);
  endproperty
  a_intensity: assert property (p_intensity) else $error("intensity bit wrong");

  property p_swap;
    @(posedge hclk) disable iff (!hresetn)
      (pclk_rise && fifo_valid && mode == MODE_TFT_555I && st_r.swap) |=> panel_data_out[5:1] == $past(word.blue);
  endproperty
  a_swap: assert property (p_swap) else $error("colour swap wrong");

  property p_still;
    @(posedge hclk) disable iff (!hresetn)
      !pclk_rise |=> $stable(panel_data_out) && $stable(frame_pulse_out) && $stable(line_pulse_out);
  endproperty
  a_still: assert property (p_still) else $error("pins moved off the panel clock edge");

  property p_unused_low;
    @(posedge hclk) disable iff (!hresetn)
      (pclk_rise && mode == MODE_MONO8_SINGLE && !st_r.thin) |=> panel_data_out[17:8] == 10'h0;
  endproperty
  a_unused_low: assert property (p_unused_low) else $error("unused outputs not low");

  property p_555_colours;
    @(posedge hclk) disable iff (!hresetn)
      (pclk_rise && fifo_valid && mode == MODE_TFT_555I && !st_r.swap)
        |=> panel_data_out[11:7] == $past(word.green[4:0]) && panel_data_out[17:13] == $past(word.blue);
  endproperty
  a_555_colours: assert property (p_555_colours) else $error("5:5:5+I green or blue map wrong");

  property p_565_colours;
    @(posedge hclk) disable iff (!hresetn)
      (pclk_rise && fifo_valid && mode == MODE_TFT_565 && !st_r.swap)
        |=> panel_data_out[17:14] == $past(word.blue[3:0]) && panel_data_out[13] == $past(word.green[5]);
  endproperty
  a_565_colours: assert property (p_565_colours) else $error("5:6:5 blue or green5 map wrong");

  property p_thin_extras;
    @(posedge hclk) disable iff (!hresetn)
      (pclk_rise && st_r.thin)
        |=> panel_data_out[6] == $past(st_r.power_save) && panel_data_out[12] == $past(st_r.reverse);
  endproperty
  a_thin_extras: assert property (p_thin_extras) else $error("power save or reverse pin wrong");

  property p_supply_pin;
    @(posedge hclk) disable iff (!hresetn)
      pclk_rise |=> panel_supply_enable == ($past(st_r.thin) ? $past(st_r.gate_clk) : $past(st_r.supply_on));
  endproperty
  a_supply_pin: assert property (p_supply_pin) else $error("supply or gate clock pin wrong");

  c_dual_stn: cover property (@(posedge hclk) pclk_rise && fifo_valid && mode == MODE_COLOUR_DUAL);
  c_tft_565:  cover property (@(posedge hclk) pclk_rise && fifo_valid && mode == MODE_TFT_565);
  c_full:     cover property (@(posedge hclk) !pix_ready);
  c_thin:     cover property (@(posedge hclk) pclk_rise && fifo_valid && st_r.thin);
  c_ext_clk:  cover property (@(posedge hclk) pclk_rise && fifo_valid && st_r.ext_clk);
endmodule

`default_nettype wire

// ### verif/panel_model.sv
// Panel-side model: latches what a panel with a timing controller would see on each pixel clock.
// Assumes the mapper launches pins on the rising pixel clock and holds them a full period.
`timescale 1ns/100ps
`default_nettype none

module panel_model
  import panel_pin_pkg::*;
(
  input  wire logic        panel_pixel_clock,
  input  wire logic [17:0] panel_data_out,
  input  wire logic        frame_pulse_out,
  input  wire logic        line_pulse_out,
  input  wire logic        panel_data_enable,
  input  wire logic        panel_supply_enable
);
  // ---------------------------------------------------------------------------
  // Capture
  // ---------------------------------------------------------------------------
  panel_pins_s cap[$];
  logic [5:0]  red_wide;

  // Latch on the falling pixel clock edge, so pins launched late or on another edge show up as wrong words.
  // A 6:6:6 panel takes the intensity pin as the LSB of each colour; red_wide holds the last red seen that way.
  always @(negedge panel_pixel_clock) begin
    if (panel_data_enable === 1'b1) begin
      cap.push_back({panel_data_out, frame_pulse_out, line_pulse_out, panel_data_enable, panel_supply_enable});
      red_wide = {panel_data_out[5:1], panel_data_out[0]};
    end
  end
endmodule

`default_nettype wire

// ### verif/lcd_panel_pin_mapper_tb.sv
// Self-checking bench for the panel pin mapper: registers over AHB-Lite, pixel stream in, panel pins out.
// Assumes the panel model in its own file and the constants header in the include path.
`timescale 1ns/100ps
`default_nettype none
`include "panel_pin_map.svh"

module lcd_panel_pin_mapper_tb;
  import panel_pin_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, pix_valid, pix_ready;
  logic        external_pixel_clock_in, ext_run, frame_pulse_out, line_pulse_out;
  logic        panel_data_enable, panel_supply_enable, panel_pixel_clock, ok;
  logic [1:0]  htrans, ext_div;
  logic [2:0]  hsize;
  logic [11:0] haddr;
  logic [31:0] hwdata, hrdata, rd;
  logic [17:0] panel_data_out;
  logic [6:0]  c;
  pixel_word_s pix_word;
  pixel_word_s exp_q[$];
  int          n_mismatch, total_checks, n_sent, m, k;
  wire         hready = hreadyout;

  lcd_panel_pin_mapper #(.FIFO_DEPTH(16), .CLK_DIV(2)) i_lcd_panel_pin_mapper (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pix_valid(pix_valid),
    .pix_ready(pix_ready), .pix_word(pix_word), .external_pixel_clock_in(external_pixel_clock_in),
    .panel_data_out(panel_data_out), .frame_pulse_out(frame_pulse_out), .line_pulse_out(line_pulse_out),
    .panel_data_enable(panel_data_enable), .panel_supply_enable(panel_supply_enable),
    .panel_pixel_clock(panel_pixel_clock));

  panel_model i_panel_model (.panel_pixel_clock(panel_pixel_clock), .panel_data_out(panel_data_out),
    .frame_pulse_out(frame_pulse_out), .line_pulse_out(line_pulse_out),
    .panel_data_enable(panel_data_enable), .panel_supply_enable(panel_supply_enable));

  // ---------------------------------------------------------------------------
  // Clocks
  // ---------------------------------------------------------------------------
  // Bus clock at 25 MHz.
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  // External pixel clock toggles every four hclk while running and parks low when stopped, stalling the panel.
  always @(posedge hclk) begin
    ext_div <= ext_div + 2'h1;
    if (ext_div == 2'h3) external_pixel_clock_in <= ext_run & ~external_pixel_clock_in;
  end

  // ---------------------------------------------------------------------------
  // Checking and reporting
  // ---------------------------------------------------------------------------
  task automatic tally_and_finish;
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic timed_out;
    n_mismatch++;
    $display("CHECK FAILED t=%0t wait ran out", $time);
    tally_and_finish();
  endtask

  task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t value got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic check_pins(input panel_pins_s got, input panel_pins_s exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t pins got %h exp %h", $time, got, exp);
    end
  endtask

  // Pin image the panel must see for one word under the given control and sideband settings.
  function automatic panel_pins_s expect_pins(input pixel_word_s w, input logic [6:0] cf, input logic [3:0] sb);
    panel_pins_s p;
    logic [4:0]  lo;
    logic [4:0]  hi;
    p = '0;
    lo = cf[4] ? w.blue : w.red;
    hi = cf[4] ? w.red : w.blue;
    case (cf[3:0])
      4'h0: p.data = {14'h0, w.upper[3:0]};
      4'h1: p.data = {6'h0, w.lower[3:0], 4'h0, w.upper[3:0]};
      4'h2, 4'h4: p.data = {10'h0, w.upper};
      4'h3, 4'h5: p.data = {2'h0, w.lower, w.upper};
      4'h6: p.data = {hi, 1'b0, w.green[4:0], 1'b0, lo, w.intensity};
      4'h7: p.data = {hi[3:0], w.green[5], 1'b0, w.green[4:0], 1'b0, lo, hi[4]};
      default: p.data = '0;
    endcase
    if (cf[5]) begin
      p.data[6] = sb[1];
      p.data[12] = sb[2];
    end
    p.frame = w.frame;
    p.line = w.line;
    p.enab = w.enable;
    p.supply = cf[5] ? sb[3] : sb[0];
    return p;
  endfunction

  // ---------------------------------------------------------------------------
  // Drivers
  // ---------------------------------------------------------------------------
  // One AHB-Lite single word transfer; each phase is held until hready is sampled high.
  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rv);
    int i;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    for (i = 0; i < 50; i++) begin @(posedge hclk); if (hready === 1'b1) break; end
    if (i == 50) timed_out();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    for (i = 0; i < 50; i++) begin @(posedge hclk); if (hready === 1'b1) break; end
    if (i == 50) timed_out();
    rv = hrdata;
  endtask

  // Offers one word and leaves valid up, so successive calls stream back to back.
  task automatic push(input pixel_word_s w, input int bound, output logic acc);
    int i;
    pix_valid <= 1'b1;
    pix_word <= w;
    acc = 1'b0;
    for (i = 0; i < bound && !acc; i++) begin
      @(posedge hclk);
      acc = (pix_ready === 1'b1);
    end
    if (acc) exp_q.push_back(w);
    if (acc) n_sent++;
  endtask

  // Waits for every accepted word to reach the panel and compares each in order.
  task automatic drain(input logic [6:0] cf, input logic [3:0] sb);
    int i;
    for (i = 0; i < 3000 && i_panel_model.cap.size() < exp_q.size(); i++) @(posedge hclk);
    if (i == 3000) timed_out();
    while (exp_q.size() > 0) begin
      check_pins(i_panel_model.cap.pop_front(), expect_pins(exp_q.pop_front(), cf, sb));
    end
  endtask

  // A burst of words in one mode; the first two are all ones and all zeros but for the enable bit.
  task automatic run_mode(input logic [6:0] cf, input logic [3:0] sb, input int n);
    logic [63:0] r;
    logic [31:0] rv;
    pixel_word_s w;
    logic        acc;
    ahb(1'b1, `PPM_OFS_CTRL, {25'h0, cf}, rv);
    ahb(1'b1, `PPM_OFS_SIDEBND, {28'h0, sb}, rv);
    for (int i = 0; i < n; i++) begin
      r = {$urandom, $urandom};
      w = r[35:0];
      if (i < 2) w = (i == 0) ? '1 : '0;
      w.enable = 1'b1;
      push(w, 50, acc);
      if (!acc) timed_out();
    end
    pix_valid <= 1'b0;
    drain(cf, sb);
    if (cf[4:0] == 5'h06) check_reg(32'(i_panel_model.red_wide), {26'h0, w.red, w.intensity});
  endtask

  // Run-length guard: 100000 bus clocks.
  initial begin
    #4000000;
    timed_out();
  end

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    {hresetn, hsel, hwrite, pix_valid, external_pixel_clock_in, ext_run} = '0;
    {haddr, htrans, hwdata, ext_div, pix_word} = '0;
    hsize = 3'h2;
    {n_mismatch, total_checks, n_sent} = '0;
    void'($urandom(32'h4d1952a1));
    repeat (20) @(posedge hclk);
    check_pins({panel_data_out, frame_pulse_out, line_pulse_out, panel_data_enable,
                panel_supply_enable}, '0);
    check_reg({31'h0, pix_ready}, 32'h1);
    hresetn <= 1'b1;
    // Reset values, a read-only write and an unmapped place.
    ahb(1'b0, `PPM_OFS_CTRL, 32'h0, rd);
    check_reg(rd, `PPM_CTRL_RESET);
    check_reg({31'h0, hresp}, 32'h0);
    ahb(1'b1, `PPM_OFS_STATUS, 32'hffff_ffff, rd);
    ahb(1'b0, `PPM_OFS_STATUS, 32'h0, rd);
    check_reg(rd, 32'h0000_0002);
    ahb(1'b1, 12'h00c, 32'hffff_ffff, rd);
    ahb(1'b0, 12'h00c, 32'h0, rd);
    check_reg(rd, 32'h0);
    // Every panel mode, then both TFT modes swapped, then both in thin-panel form.
    for (m = 0; m < 12; m++) begin
      c = (m < 8) ? 7'(m) : 7'(6 + m % 2);
      if (m >= 8) c[4] = (m < 10) | (m == 11);
      c[5] = (m >= 10);
      run_mode(c, 4'($urandom), 6);
    end
    // External clock parked: the panel stalls, so the buffer fills until it refuses.
    c = 7'h46;
    ahb(1'b1, `PPM_OFS_SIDEBND, 32'h0, rd);
    ahb(1'b1, `PPM_OFS_CTRL, {25'h0, c}, rd);
    k = 0;
    ok = 1'b1;
    while (ok && k < 40) begin
      push(pixel_word_s'({$urandom, 4'h1}), 8, ok);
      if (ok) k++;
    end
    pix_valid <= 1'b0;
    check_reg(32'(k), 32'd16);
    ahb(1'b0, `PPM_OFS_STATUS, 32'h0, rd);
    check_reg({30'h0, rd[1:0]}, 32'h1);
    ext_run <= 1'b1;
    drain(c, 4'h0);
    ext_run <= 1'b0;
    ahb(1'b0, `PPM_OFS_STATUS, 32'h0, rd);
    check_reg(rd, {n_sent[15:0], 16'h0002});
    tally_and_finish();
  end
endmodule

`default_nettype wire
